// file: rtl/acd_decoder.sv
/*
  Command decoder for the serial port of a sensor ADC.
  Assumes a byte deframer on core_clk presents each received byte as a one-cycle
  valid pulse, and takes each transmit byte on a one-cycle request pulse.
  The last byte of a write arrives at the final falling edge; the decoder finds it by its own count.
  Every input comes from logic on core_clk, so none of them is synchronised here.
  The conversion side reads conv_ctl and sleep_cmd and reports conv_busy and the
  latest two's complement result; continuous_mode is a level from that side.
  The host is expected to keep to the settling time after a reset command; the
  design only shows that window on reset_hold and keeps decoding meanwhile.
  The 32 conversion-clock part of that window is not counted here, as the
  conversion clock is not seen by this block.
  Bytes of a write land one by one, so a write cut short leaves the bytes that
  did arrive in place.
  A readback or a fetch must be drained completely before the next command,
  since bytes that arrive meanwhile are dropped without a trace.
  Unknown opcodes are dropped the same way.
*/
`timescale 1ns/1ps
module acd_decoder #(
  parameter int RESET_WAIT_CYCLES = acd_pkg::ACD_RESET_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Received bytes
  input acd_pkg::acd_byte_type rx_byte,
  // Transmit byte request from the deframer
  input wire logic tx_req,
  output logic [7:0] tx_data,
  // Conversion side
  input wire logic continuous_mode,
  input wire logic conv_busy,
  input wire logic [15:0] conv_result,
  output acd_pkg::acd_conv_type conv_ctl,
  output logic sleep_cmd,
  // Configuration and status
  output logic [31:0] config_regs,
  output logic cmd_busy,
  output logic reset_hold
);
  import acd_pkg::*;

  typedef enum logic [1:0] {
    ACD_IDLE = 2'b00,
    ACD_FETCH = 2'b01,
    ACD_READBACK = 2'b10,
    ACD_WRITE = 2'b11
  } acd_state_type;

  acd_state_type state_q;
  logic [7:0] regs_q [ACD_NUM_REGS];
  logic [1:0] idx_q;
  logic [1:0] left_q;
  logic [0:0] fetch_left_q;
  logic [15:0] fetch_data_q;
  logic [31:0] hold_cnt_q;
  logic [7:0] b;
  logic idle_cmd;
  logic is_reset;
  logic is_start;
  logic is_sleep;
  logic is_fetch;
  logic is_read;
  logic is_write;
  logic run_q;
  // Pointer step of a readback or a write, and the per-register write strobes.
  logic step;
  logic [ACD_NUM_REGS-1:0] wr_en;

  assign b = rx_byte.data;
  assign idle_cmd = rx_byte.valid && state_q == ACD_IDLE; // RQ17
  assign cmd_busy = state_q != ACD_IDLE;
  assign reset_hold = hold_cnt_q != 32'h0;
  assign step = (state_q == ACD_READBACK && tx_req) ||
    (state_q == ACD_WRITE && rx_byte.valid);

  // Decode of a byte taken while idle. Only the exact patterns decode; any
  // other byte leaves every flag low, so state and registers stay unchanged.
  // The nibble-wide opcodes (fetch, readback, write) are tested first, as only their upper nibble decodes.
  always_comb begin
    is_reset = 1'b0;
    is_start = 1'b0;
    is_sleep = 1'b0;
    is_fetch = 1'b0;
    is_read = 1'b0;
    is_write = 1'b0;
    if (!idle_cmd) begin
      is_reset = 1'b0;
    end else if (b[7:4] == ACD_OP_FETCH) begin
      is_fetch = 1'b1; // RQ9
    end else if (b[7:4] == ACD_OP_READBACK) begin
      is_read = 1'b1; // RQ10
    end else if (b[7:4] == ACD_OP_WRITE) begin
      is_write = 1'b1; // RQ11
    end else if (b[7:1] == ACD_OP_RESET) begin
      is_reset = 1'b1; // RQ1 RQ8
    end else if (b[7:1] == ACD_OP_START) begin
      is_start = 1'b1; // RQ3 RQ8
    end else if (b[7:1] == ACD_OP_SLEEP) begin
      is_sleep = 1'b1; // RQ8
    end else begin
      is_reset = 1'b0; // RQ18
    end
  end

  // Configuration registers, one per entry. Each byte of a write lands as it
  // completes, the last one on the byte that carries the final falling edge.
  genvar gi;
  generate
    for (gi = 0; gi < ACD_NUM_REGS; gi++) begin : g_cfg
      assign wr_en[gi] = state_q == ACD_WRITE && rx_byte.valid && idx_q == 2'(gi); // RQ15
      always_ff @(posedge core_clk) begin
        if (sys_rst || is_reset) begin
          regs_q[gi] <= ACD_REG_RESET; // RQ1 RQ16
        end else if (wr_en[gi]) begin
          regs_q[gi] <= b;
        end
      end
      assign config_regs[gi*8 +: 8] = regs_q[gi];
    end
  endgenerate

  // Command state. Only the idle state looks at new opcodes, so bytes that
  // arrive during a fetch or a readback are dropped.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ACD_IDLE;
    end else begin
      case (state_q)
        ACD_IDLE: begin
          if (is_fetch) begin
            state_q <= ACD_FETCH;
          end else if (is_read) begin
            state_q <= ACD_READBACK;
          end else if (is_write) begin
            state_q <= ACD_WRITE;
          end
        end
        ACD_FETCH: begin
          if (tx_req) begin
            if (fetch_left_q == 1'b0) begin
              state_q <= ACD_IDLE; // RQ17
            end
          end
        end
        ACD_READBACK: begin
          if (tx_req) begin
            if (left_q == 2'b00) begin
              state_q <= ACD_IDLE; // RQ14
            end
          end
        end
        ACD_WRITE: begin
          if (rx_byte.valid) begin
            if (left_q == 2'b00) begin
              state_q <= ACD_IDLE;
            end
          end
        end
        default: begin
          state_q <= ACD_IDLE;
        end
      endcase
    end
  end

  // Result bytes still to be handed out during a fetch, held as count minus one.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetch_left_q <= 1'b0;
    end else if (is_fetch) begin
      fetch_left_q <= 1'(ACD_RESULT_BYTES - 1);
    end else if (state_q == ACD_FETCH && tx_req) begin
      fetch_left_q <= fetch_left_q - 1'b1;
    end
  end

  // Register pointer; it wraps past the last register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idx_q <= 2'b00;
    end else if (is_read || is_write) begin
      idx_q <= b[ACD_IDX_MSB:ACD_IDX_LSB]; // RQ12
    end else if (step) begin
      idx_q <= idx_q + 2'b01;
    end
  end

  // Bytes left in a readback or a write, held as count minus one.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      left_q <= 2'b00;
    end else if (is_read || is_write) begin
      left_q <= b[ACD_CNT_MSB:ACD_CNT_LSB]; // RQ12
    end else if (step) begin
      left_q <= left_q - 2'b01;
    end
  end

  // Result snapshot taken with the fetch opcode, so that both bytes belong
  // to one conversion even if the result moves during the transfer.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fetch_data_q <= 16'h0000;
    end else if (is_fetch) begin
      fetch_data_q <= conv_result; // RQ13
    end
  end

  // Transmit data: result bytes MSB first, or register bytes. Each byte is
  // ready one clock before the deframer can ask for it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_data <= 8'h00;
    end else begin
      case (state_q)
        ACD_IDLE: begin
          if (is_fetch) begin
            tx_data <= conv_result[15:8];
          end else if (is_read) begin
            tx_data <= regs_q[b[ACD_IDX_MSB:ACD_IDX_LSB]];
          end
        end
        ACD_FETCH: begin
          if (tx_req) begin
            tx_data <= fetch_data_q[7:0];
          end
        end
        ACD_READBACK: begin
          if (tx_req) begin
            tx_data <= regs_q[idx_q + 2'b01];
          end
        end
        default: begin
          tx_data <= tx_data;
        end
      endcase
    end
  end

  // Conversion control pulses. A start during a running conversion pulses filter_clear
  always_ff @(posedge core_clk) begin
    if (sys_rst || is_reset) begin
      conv_ctl <= '0;
    end else begin
      conv_ctl.start <= is_start; // RQ4 RQ6
      conv_ctl.filter_clear <= is_start && (conv_busy || (continuous_mode && run_q)); // RQ5 RQ7
    end
  end

  // Continuous sequence running; conv_busy may drop between conversions.
  always_ff @(posedge core_clk) begin
    if (sys_rst || is_reset) begin
      run_q <= 1'b0;
    end else if (is_start) begin
      run_q <= continuous_mode; // RQ6
    end
  end

  // Sleep level; held until a start or a reset. The registers are untouched.
  always_ff @(posedge core_clk) begin
    if (sys_rst || is_reset) begin
      sleep_cmd <= 1'b0;
    end else if (is_start) begin
      sleep_cmd <= 1'b0;
    end else if (is_sleep) begin
      sleep_cmd <= 1'b1;
    end
  end

  // Settling window after a reset command, shown for the host. A reset
  // command during the window starts it again from the full count.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_cnt_q <= 32'h0;
    end else if (is_reset) begin
      hold_cnt_q <= 32'(RESET_WAIT_CYCLES); // RQ2
    end else if (hold_cnt_q != 32'h0) begin
      hold_cnt_q <= hold_cnt_q - 32'h1;
    end
  end
endmodule

// file: shared/acd_pkg.sv
/*
  Constants and carrier types for the serial command decoder of a sensor ADC.
  Assumes one 100 MHz core clock and a synchronous active-high reset.
*/
// Notes on behaviour
// (RQ1) Reset opcode restores all configuration defaults
// (RQ2) Host waits 50 us plus 32 clocks
// (RQ3) 0000 100x is start or restart
// (RQ4) Single-shot idle start launches one conversion
// (RQ5) Single-shot busy start clears filter, restarts
// (RQ6) Continuous mode converts repeatedly after one start
// (RQ7) Continuous busy start clears filter, restarts sequence
// (RQ8) Reset, start, sleep, fetch take no operands
// (RQ9) Upper nibble 0001 is result fetch
// (RQ10) Upper nibble 0010 is configuration readback
// (RQ11) Upper nibble 0100 is configuration write
// (RQ12) Index selects register; count is bytes minus one
// (RQ13) Result is two's complement sixteen bits
// (RQ14) Readback ends after count plus one bytes
// (RQ15) Write registers update on final falling edge; here each byte lands as it completes
// (RQ16) Four 8-bit registers, zero after reset, kept
// (RQ17) No decoding during fetch or readback
// (RQ18) Unknown opcodes are ignored
package acd_pkg;
  localparam int ACD_NUM_REGS = 4;
  localparam logic [7:0] ACD_REG_RESET = 8'h00;
  localparam logic [6:0] ACD_OP_RESET = 7'h03;
  localparam logic [6:0] ACD_OP_START = 7'h04;
  localparam logic [6:0] ACD_OP_SLEEP = 7'h01;
  localparam logic [3:0] ACD_OP_FETCH = 4'h1;
  localparam logic [3:0] ACD_OP_READBACK = 4'h2;
  localparam logic [3:0] ACD_OP_WRITE = 4'h4;
  localparam int ACD_IDX_MSB = 3;
  localparam int ACD_IDX_LSB = 2;
  localparam int ACD_CNT_MSB = 1;
  localparam int ACD_CNT_LSB = 0;
  localparam int ACD_RESULT_BYTES = 2;
  localparam int ACD_CLK_MHZ = 100;
  localparam int ACD_RESET_WAIT_US = 50;
  localparam int ACD_RESET_WAIT_CONV_CLKS = 32;
  localparam int ACD_RESET_WAIT_CYCLES = ACD_RESET_WAIT_US * ACD_CLK_MHZ;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } acd_byte_type;

  typedef struct packed {
    logic start;
    logic filter_clear;
  } acd_conv_type;
endpackage

// file: sim/acd_checker_assertions.sv
/*
  Port checker for the command decoder.
  Assumes it is bound to acd_decoder.
*/
`timescale 1ns/1ps
module acd_checker import acd_pkg::*; (
  // Watched ports
  input wire logic core_clk,
  input wire logic sys_rst,
  input acd_byte_type rx_byte,
  input logic [7:0] tx_data,
  input wire logic conv_busy,
  input wire logic [15:0] conv_result,
  input acd_conv_type conv_ctl,
  input logic sleep_cmd,
  input logic [31:0] config_regs,
  input logic cmd_busy,
  input logic reset_hold
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic tk;
  logic [7:0] op;
  assign tk = rx_byte.valid && !cmd_busy && !reset_hold;
  assign op = rx_byte.data;
  AST_START: assert property (tk && op[7:1] == ACD_OP_START |=> conv_ctl.start)
    else $error("no start");
  AST_CLR: assert property (tk && op[7:1] == 7'h04 && conv_busy |=> conv_ctl.filter_clear)
    else $error("no clear");
  AST_RST: assert property (tk && op[7:1] == ACD_OP_RESET |=> config_regs == 0)
    else $error("no reset");
  AST_SLP: assert property (tk && op[7:1] == ACD_OP_SLEEP |=> sleep_cmd)
    else $error("no sleep");
  AST_FETCH: assert property (tk && op[7:4] == 4'h1 |=> {8'h00, tx_data} == $past(conv_result) >> 8)
    else $error("bad fetch");
  AST_RB: assert property (tk && op[7:4] == 4'h2 |=> cmd_busy)
    else $error("no readback");
  AST_UNK: assert property (tk && !(op[7:4] inside {1, 2, 4}) && !(op[7:1] inside {1, 3, 4})
    |=> $stable(config_regs) && !conv_ctl.start && !cmd_busy)
    else $error("odd opcode acted");
  AST_KEEP: assert property (!cmd_busy && !rx_byte.valid |=> $stable(config_regs))
    else $error("regs moved");
  cover property (tk && op[7:4] == 4'h4);
  cover property (tk && op[7:4] == 4'h1);
  cover property (conv_ctl.filter_clear);
endmodule
bind acd_decoder acd_checker u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .rx_byte(rx_byte),
  .tx_data(tx_data),
  .conv_busy(conv_busy),
  .conv_result(conv_result),
  .conv_ctl(conv_ctl),
  .sleep_cmd(sleep_cmd),
  .config_regs(config_regs),
  .cmd_busy(cmd_busy),
  .reset_hold(reset_hold)
);

// file: sim/acd_host.sv
/*
  Host model: sends command bytes and pulls reply bytes.
  Assumes the byte-level contract of the decoder.
*/
`timescale 1ns/1ps
module acd_host import acd_pkg::*; (
  // Link to decoder
  input wire logic core_clk,
  input wire logic [7:0] tx_data,
  output acd_byte_type rx_byte,
  output logic tx_req
);
  initial begin
    rx_byte = '0;
    tx_req = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge core_clk);
    rx_byte <= {1'b1, b};
    @(posedge core_clk);
    rx_byte <= {1'b0, ~b};
  endtask
  task automatic pull(input int gap, output logic [7:0] b);
    repeat (gap) @(posedge core_clk);
    #1;
    b = tx_data;
    @(posedge core_clk);
    tx_req <= 1'b1;
    @(posedge core_clk);
    tx_req <= 1'b0;
  endtask
endmodule

// file: sim/testbench.sv
/*
  Self-checking bench for the command decoder.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  import acd_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic continuous_mode = 1'b0;
  logic conv_busy = 1'b0;
  logic [15:0] conv_result = 16'h0000;
  acd_byte_type rx_byte;
  acd_conv_type conv_ctl;
  logic tx_req, sleep_cmd, cmd_busy, reset_hold;
  logic [7:0] tx_data, b;
  logic [31:0] config_regs;
  logic [7:0] rb [3] = '{8'h33, 8'h44, 8'h11};
  int n_fail = 0;
  int comparisons = 0;
  initial forever #5 core_clk = ~core_clk;
  acd_host host (
    .core_clk(core_clk),
    .tx_data(tx_data),
    .rx_byte(rx_byte),
    .tx_req(tx_req)
  );
  acd_decoder #(.RESET_WAIT_CYCLES(8)) DUT (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .rx_byte(rx_byte),
    .tx_req(tx_req),
    .tx_data(tx_data),
    .continuous_mode(continuous_mode),
    .conv_busy(conv_busy),
    .conv_result(conv_result),
    .conv_ctl(conv_ctl),
    .sleep_cmd(sleep_cmd),
    .config_regs(config_regs),
    .cmd_busy(cmd_busy),
    .reset_hold(reset_hold)
  );
  function automatic bit ne(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    return a !== e;
  endfunction
  task automatic err(input string m);
    n_fail++;
    $display("Error %0t %s", $time, m);
  endtask
  task automatic give_verdict;
    $display("fails %0d checks %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_write_read;
    host.send(8'h47);
    for (int i = 1; i < 5; i++) host.send(8'h11 * i[7:0]);
    @(posedge core_clk);
    #1;
    if (ne(config_regs, 32'h33221144)) err("write wrap");
    host.send(8'h2E);
    for (int i = 0; i < 3; i++) begin
      host.pull(i + 1, b);
      if (ne(b, rb[i])) err("readback");
    end
    #1;
    if (ne(cmd_busy, 0)) err("still busy");
  endtask
  task automatic t_fetch;
    conv_result <= 16'h8001;
    host.send(8'h1C);
    host.send(8'h09);
    #1;
    if (ne(conv_ctl.start, 0)) err("decoded mid fetch");
    host.pull(1, b);
    if (ne(b, 8'h80)) err("high byte");
    host.pull(3, b);
    if (ne(b, 8'h01)) err("low byte");
  endtask
  task automatic t_start;
    for (int i = 0; i < 5; i++) begin
      continuous_mode <= (i >= 2);
      conv_busy <= (i == 1 || i == 4);
      host.send(8'h08 | i[7:0] & 8'h01);
      #1;
      if (ne(conv_ctl.start, 1)) err("no start");
      if (ne(conv_ctl.filter_clear, 32'(i == 1 || i >= 3))) err("clear");
    end
    conv_busy <= 1'b0;
  endtask
  task automatic t_sleep_reset;
    host.send(8'h03);
    host.send(8'h80);
    host.send(8'h31);
    @(posedge core_clk);
    #1;
    if (ne({sleep_cmd, config_regs[30:0]}, 32'hB3221144)) err("sleep");
    host.send(8'h07);
    @(posedge core_clk);
    #1;
    if (ne(config_regs, 0) || sleep_cmd !== 1'b0) err("reset");
    for (int k = 0; k < 20 && reset_hold !== 1'b0; k++) @(posedge core_clk);
    if (reset_hold !== 1'b0) begin
      err("hold hung");
      give_verdict();
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_write_read();
    t_fetch();
    t_sleep_reset();
    t_start();
    give_verdict();
  end
endmodule
